// >>> sec_consts.vh
`ifndef SEC_CONSTS_VH
`define SEC_CONSTS_VH

// Opcode matching: bit 3 is masked off for the short opcodes
`define SEC_OPC_MASK_X     8'hF7
`define SEC_OPC_UNLOCK     8'h06
`define SEC_OPC_LOCK       8'h04
`define SEC_OPC_STAT_RD    8'h05
`define SEC_OPC_STAT_WR    8'h01
`define SEC_OPC_ARRAY_RD   8'h03
`define SEC_OPC_ARRAY_WR   8'h02
`define SEC_OPC_IDPAGE_RD  8'h83
`define SEC_OPC_IDPAGE_WR  8'h82
`define SEC_OPC_TOP_BIT    3

// Address byte bit that picks the lock function over page access
`define SEC_ADDR_LOCK_BIT  7

// Status byte layout
`define SEC_STAT_ONES      4'hF
`define SEC_STAT_PROT_HI   3
`define SEC_STAT_PROT_LO   2
`define SEC_STAT_LATCH     1
`define SEC_STAT_BUSY      0

// Protection encodings
`define SEC_PROT_NONE      2'h0
`define SEC_PROT_QUARTER   2'h1
`define SEC_PROT_HALF      2'h2
`define SEC_PROT_ALL       2'h3
`define SEC_PROT_RESET     2'h0

// Kinds of self-timed cycle
`define SEC_NV_STATUS      2'h0
`define SEC_NV_ARRAY       2'h1
`define SEC_NV_IDPAGE      2'h2
`define SEC_NV_SEAL        2'h3

// Self-timed cycle length
`define SEC_TW_NS          5000000
`define SEC_CLK_MHZ        200
`define SEC_TW_CYC         ((`SEC_TW_NS * `SEC_CLK_MHZ) / 1000)

`endif

// >>> sec_cmd.v
// Summary of operation
// - Bytes arrive MSB first, opcode byte first
// - Unknown opcode: ignore everything until deselect
// - Decode unlock and lock, bit 3 ignored
// - Decode status read and write, bit 3 ignored
// - Array read/write opcodes carry top address bit
// - Top address bit selects array half
// - Address bit 7 picks page or lock function
// - Unlock command sets the write latch
// - After unlock/lock opcode, ignore input until deselect
// - Latch cleared: reset, lock, completion, protect pin
// - Status byte repeats until deselect
// - Status read accepted even while busy
// - New protect bits visible after cycle only
// - Status byte: ones, protect, latch, busy
// - Busy flag high during self-timed cycle
// - Latch clear rejects array and status writes
// - Protect bits non-volatile, block protected writes
// - Deselect exactly at byte boundary to execute
// - Valid status write starts timed busy cycle
// - Status write changes only protect bits
// - Status write rejected: latch, busy, protect pin
// - Protect code selects none, quarter, half, all
// - While busy ignore array and status writes
// - Sample on rising, shift out after falling
`include "sec_consts.vh"
`default_nettype none

module sec_cmd #(
  parameter integer TW_CYC = `SEC_TW_CYC
) (
  // System
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  // Serial pins
  input  wire       i_spi_sclk,
  input  wire       i_spi_cs_n,
  input  wire       i_spi_mosi,
  input  wire       i_wp_n,
  output reg        o_spi_miso,
  output reg        o_spi_miso_oe_n,
  // Decoded requests to the data paths
  output reg        o_array_rd,
  output reg        o_idpage_rd,
  output reg        o_lock_query,
  output reg  [8:0] o_addr,
  output reg  [7:0] o_rx_byte,
  output reg        o_rx_byte_vld,
  // Self-timed cycle
  output reg        o_nv_start,
  output reg  [1:0] o_nv_kind,
  output reg        o_busy,
  // Status
  output wire [7:0] o_status
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_OPC  = 6'h02;
  localparam [5:0] ST_ADDR = 6'h04;
  localparam [5:0] ST_DATA = 6'h08;
  localparam [5:0] ST_STAT = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;

  localparam [2:0] K_ARD = 3'h0;
  localparam [2:0] K_AWR = 3'h1;
  localparam [2:0] K_SWR = 3'h2;
  localparam [2:0] K_IDR = 3'h3;
  localparam [2:0] K_IDW = 3'h4;

  // Write to the protected region of a 9-bit array
  function prot_hit;
    input [8:0] addr;
    input [1:0] prot;
    begin
      case (prot)
        `SEC_PROT_NONE:    prot_hit = 1'b0;
        `SEC_PROT_QUARTER: prot_hit = (addr[8:7] == 2'h3);
        `SEC_PROT_HALF:    prot_hit = addr[8];
        default:           prot_hit = 1'b1;
      endcase
    end
  endfunction

  // Opcode match with bit 3 masked
  function opc_x;
    input [7:0] opc;
    input [7:0] code;
    begin
      opc_x = ((opc & `SEC_OPC_MASK_X) == code);
    end
  endfunction

  reg        cs_m;
  reg        cs_s;
  reg        cs_d;
  reg        sck_m;
  reg        sck_s;
  reg        sck_d;
  reg        mosi_m;
  reg        mosi_s;
  reg        wp_m;
  reg        wp_s;

  reg  [5:0] state;
  reg  [2:0] kind;
  reg  [2:0] bit_cnt;
  reg  [2:0] obit_cnt;
  reg  [6:0] sh_in;
  reg  [7:0] sh_out;
  reg        top_bit;
  reg  [7:0] addr_byte;
  reg        armed;
  reg        extra_byte;
  reg        wp_low_seen;
  reg  [1:0] pend_prot;
  reg  [1:0] prot;
  reg        latch;
  reg  [23:0] timer;
  reg  [1:0] cyc_kind;

  wire       sck_rise = sck_s & ~sck_d;
  wire       sck_fall = ~sck_s & sck_d;
  wire       cs_fall  = ~cs_s & cs_d;
  wire       cs_rise  = cs_s & ~cs_d;
  wire       selected = ~cs_s & ~cs_d;
  wire [7:0] rx_byte  = {sh_in, mosi_s};
  wire       byte_done = selected & sck_rise & (bit_cnt == 3'h7);
  wire       cyc_end  = (timer == 24'h1);
  wire [8:0] full_addr = {top_bit, addr_byte};

  // Status byte layout
  assign o_status = {`SEC_STAT_ONES, prot, latch, o_busy};

  // Commit checks at deselect
  reg        next_go;
  reg  [1:0] next_go_kind;
  always @*
  begin
    next_go      = 1'b0;
    next_go_kind = `SEC_NV_STATUS;
    if (cs_rise && state == ST_DATA && armed && bit_cnt == 3'h0 &&
        latch && !o_busy && !wp_low_seen && wp_s)
    begin
      case (kind)
        K_SWR:
        begin
          next_go      = !extra_byte;
          next_go_kind = `SEC_NV_STATUS;
        end
        K_AWR:
        begin
          next_go      = !prot_hit(full_addr, prot);
          next_go_kind = `SEC_NV_ARRAY;
        end
        K_IDW:
        begin
          next_go      = (prot != `SEC_PROT_ALL);
          next_go_kind = addr_byte[`SEC_ADDR_LOCK_BIT] ?
                         `SEC_NV_SEAL : `SEC_NV_IDPAGE;
        end
        default:
        begin
          next_go      = 1'b0;
          next_go_kind = `SEC_NV_STATUS;
        end
      endcase
    end
  end

  // Two-stage synchronisers on pins
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cs_m   <= 1'b1;
      cs_s   <= 1'b1;
      cs_d   <= 1'b1;
      sck_m  <= 1'b0;
      sck_s  <= 1'b0;
      sck_d  <= 1'b0;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
      wp_m   <= 1'b1;
      wp_s   <= 1'b1;
    end
    else
    begin
      cs_m   <= i_spi_cs_n;
      cs_s   <= cs_m;
      cs_d   <= cs_s;
      sck_m  <= i_spi_sclk;
      sck_s  <= sck_m;
      sck_d  <= sck_s;
      mosi_m <= i_spi_mosi;
      mosi_s <= mosi_m;
      wp_m   <= i_wp_n;
      wp_s   <= wp_m;
    end
  end

  // Command sequencer
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state         <= ST_IDLE;
      kind          <= K_ARD;
      bit_cnt       <= 3'h0;
      sh_in         <= 7'h00;
      top_bit       <= 1'b0;
      addr_byte     <= 8'h00;
      armed         <= 1'b0;
      extra_byte    <= 1'b0;
      wp_low_seen   <= 1'b0;
      pend_prot     <= `SEC_PROT_RESET;
      o_array_rd    <= 1'b0;
      o_idpage_rd   <= 1'b0;
      o_lock_query  <= 1'b0;
      o_addr        <= 9'h000;
      o_rx_byte     <= 8'h00;
      o_rx_byte_vld <= 1'b0;
    end
    else
    begin
      o_array_rd    <= 1'b0;
      o_idpage_rd   <= 1'b0;
      o_lock_query  <= 1'b0;
      o_rx_byte_vld <= 1'b0;
      if (selected && !wp_s)
        wp_low_seen <= 1'b1;
      if (selected && sck_rise)
      begin
        sh_in   <= rx_byte[6:0];
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (cs_fall)
      begin
        state       <= ST_OPC;
        bit_cnt     <= 3'h0;
        armed       <= 1'b0;
        extra_byte  <= 1'b0;
        wp_low_seen <= ~wp_s;
      end
      else if (cs_rise)
        state <= ST_IDLE;
      else if (byte_done)
      begin
        case (state)
          ST_OPC:
          begin
            if (opc_x(rx_byte, `SEC_OPC_UNLOCK) ||
                opc_x(rx_byte, `SEC_OPC_LOCK))
              state <= ST_WAIT;
            else if (opc_x(rx_byte, `SEC_OPC_STAT_RD))
              state <= ST_STAT;
            else if (opc_x(rx_byte, `SEC_OPC_STAT_WR))
            begin
              kind  <= K_SWR;
              state <= o_busy ? ST_WAIT : ST_DATA;
            end
            else if (rx_byte[7:4] == 4'h0 && rx_byte[2:1] == 2'h1)
            begin
              kind    <= rx_byte[0] ? K_ARD : K_AWR;
              top_bit <= rx_byte[`SEC_OPC_TOP_BIT];
              state   <= o_busy ? ST_WAIT : ST_ADDR;
            end
            else if (rx_byte == `SEC_OPC_IDPAGE_RD ||
                     rx_byte == `SEC_OPC_IDPAGE_WR)
            begin
              kind    <= rx_byte[0] ? K_IDR : K_IDW;
              top_bit <= rx_byte[`SEC_OPC_TOP_BIT];
              state   <= o_busy ? ST_WAIT : ST_ADDR;
            end
            else
              state <= ST_WAIT;
          end
          ST_ADDR:
          begin
            addr_byte <= rx_byte;
            o_addr    <= {top_bit, rx_byte};
            if (kind == K_ARD)
            begin
              o_array_rd <= 1'b1;
              state      <= ST_WAIT;
            end
            // lock or page by bit 7
            else if (kind == K_IDR)
            begin
              o_idpage_rd  <= ~rx_byte[`SEC_ADDR_LOCK_BIT];
              o_lock_query <= rx_byte[`SEC_ADDR_LOCK_BIT];
              state        <= ST_WAIT;
            end
            else
              state <= ST_DATA;
          end
          ST_DATA:
          begin
            o_rx_byte     <= rx_byte;
            o_rx_byte_vld <= 1'b1;
            armed         <= 1'b1;
            if (armed)
              extra_byte <= 1'b1;
            if (kind == K_SWR && !armed)
              pend_prot <= rx_byte[`SEC_STAT_PROT_HI:`SEC_STAT_PROT_LO];
          end
          default:
            state <= state;
        endcase
      end
    end
  end

  // Status shift-out
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sh_out          <= 8'h00;
      obit_cnt        <= 3'h0;
      o_spi_miso      <= 1'b0;
      o_spi_miso_oe_n <= 1'b1;
    end
    else if (!selected || state != ST_STAT)
    begin
      obit_cnt        <= 3'h0;
      o_spi_miso_oe_n <= 1'b1;
    end
    else if (sck_fall)
    begin
      obit_cnt        <= obit_cnt + 3'h1;
      o_spi_miso_oe_n <= 1'b0;
      if (obit_cnt == 3'h0)
      begin
        sh_out     <= {o_status[6:0], 1'b0};
        o_spi_miso <= o_status[7];
      end
      else
      begin
        sh_out     <= {sh_out[6:0], 1'b0};
        o_spi_miso <= sh_out[7];
      end
    end
  end

  // Latch, protect bits and timed cycle
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      latch      <= 1'b0;
      prot       <= `SEC_PROT_RESET;
      timer      <= 24'h000000;
      o_busy     <= 1'b0;
      o_nv_start <= 1'b0;
      o_nv_kind  <= `SEC_NV_STATUS;
      cyc_kind   <= `SEC_NV_STATUS;
    end
    else
    begin
      o_nv_start <= next_go;
      if (next_go)
      begin
        timer     <= TW_CYC[23:0];
        o_busy    <= 1'b1;
        o_nv_kind <= next_go_kind;
        cyc_kind  <= next_go_kind;
      end
      else if (o_busy)
      begin
        timer <= timer - 24'h000001;
        if (cyc_end)
        begin
          o_busy <= 1'b0;
          if (cyc_kind == `SEC_NV_STATUS)
            prot <= pend_prot;
        end
      end
      if (!wp_s || (o_busy && cyc_end))
        latch <= 1'b0;
      else if (byte_done && state == ST_OPC)
      begin
        if (opc_x(rx_byte, `SEC_OPC_UNLOCK))
          latch <= 1'b1;
        else if (opc_x(rx_byte, `SEC_OPC_LOCK))
          latch <= 1'b0;
      end
    end
  end

endmodule // sec_cmd

`default_nettype wire

// >>> sec_cmd_monitor.sv
`default_nettype none
module sec_cmd_monitor #(
  parameter int TW_CYC = 50
) (
  // System
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  // Serial pins
  input wire logic       i_spi_sclk,
  input wire logic       i_spi_cs_n,
  input wire logic       i_spi_mosi,
  input wire logic       i_wp_n,
  input wire logic       o_spi_miso,
  input wire logic       o_spi_miso_oe_n,
  // Decoded requests
  input wire logic       o_array_rd,
  input wire logic       o_idpage_rd,
  input wire logic       o_lock_query,
  input wire logic [8:0] o_addr,
  input wire logic [7:0] o_rx_byte,
  input wire logic       o_rx_byte_vld,
  // Timed cycle and status
  input wire logic       o_nv_start,
  input wire logic [1:0] o_nv_kind,
  input wire logic       o_busy,
  input wire logic [7:0] o_status
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  int bcnt;
  // Busy length counter
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
      bcnt <= 0;
    else
      bcnt <= o_busy ? bcnt + 1 : 0;
  a_status_ones: assert property (o_status[7:4] == 4'hF)
    else $error("status top nibble not ones");
  a_busy_cause: assert property ($rose(o_busy) |-> o_nv_start)
    else $error("busy raised without a cycle start");
  a_start_busy: assert property (o_nv_start |=> o_busy)
    else $error("no busy after start");
  a_start_latch: assert property (o_nv_start |-> o_status[1])
    else $error("start with latch clear");
  a_busy_no_start: assert property ($past(o_busy) && o_busy |-> !o_nv_start)
    else $error("start while busy");
  a_busy_max: assert property (o_busy |-> bcnt <= TW_CYC + 2)
    else $error("busy too long");
  a_busy_min: assert property ($fell(o_busy) |-> bcnt >= TW_CYC - 2)
    else $error("busy too short");
  a_latch_end: assert property ($fell(o_busy) |-> !o_status[1])
    else $error("latch kept after cycle");
  a_wp_latch: assert property (!i_wp_n [*5] |-> !o_status[1])
    else $error("latch set with protect pin low");
  a_prot_hold: assert property ($changed(o_status[3:2]) |-> !o_busy)
    else $error("protect bits moved while busy");
  a_oe_idle: assert property (i_spi_cs_n [*6] |-> o_spi_miso_oe_n)
    else $error("output driven while deselected");
  c_start: cover property (o_nv_start);
  c_done: cover property ($fell(o_busy));
  c_drive: cover property (!o_spi_miso_oe_n);
endmodule // sec_cmd_monitor
`default_nettype wire

// >>> sec_spi_master.sv
`default_nettype none
module sec_spi_master (
  // Pins
  input  wire logic       i_miso,
  output var  logic       o_sclk,
  output var  logic       o_cs_n,
  output var  logic       o_mosi,
  // Received byte
  output var  logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  event got;
  logic idle_hi;
  initial
  begin
    idle_hi = 1'b0;
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_rx = 8'h00;
  end
  // Idle clock level: low for mode 0, high for mode 3
  task automatic set_mode(input logic hi);
    idle_hi = hi;
  endtask
  // msb first, rise sampled
  // Delays are whole system periods, so pins move off its rising edge
  task automatic frame(input int nb, input logic [31:0] v, input int nrd);
    int k;
    o_sclk = idle_hi;
    #60 o_cs_n = 1'b0;
    #60;
    for (k = 0; k < nb + 8 * nrd; k++)
    begin
      o_sclk = 1'b0;
      o_mosi = (k < nb) ? v[nb - 1 - k] : ~o_mosi;
      #65 o_sclk = 1'b1;
      if (k >= nb)
        o_rx = {o_rx[6:0], i_miso};
      if (k >= nb && (k - nb) % 8 == 7)
        -> got;
      #60;
    end
    o_sclk = idle_hi;
    #65 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #60;
  endtask
endmodule // sec_spi_master
`default_nettype wire

// >>> sec_cmd_tb_top.sv
`default_nettype none
module sec_cmd_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TW = 800;
  logic i_clk_sys, i_rst_n, i_spi_sclk, i_spi_cs_n, i_spi_mosi, i_wp_n;
  logic o_spi_miso, o_spi_miso_oe_n, o_array_rd, o_idpage_rd;
  logic o_lock_query, o_rx_byte_vld, o_nv_start, o_busy;
  logic [8:0] o_addr;
  logic [7:0] o_rx_byte, o_status, m_rx;
  logic [1:0] o_nv_kind;
  logic [11:0] q[$];
  logic [15:0] lf = 16'hF8B7;
  int err_total, samples_checked, n;
  sec_cmd #(.TW_CYC(TW)) dut (.i_clk_sys, .i_rst_n, .i_spi_sclk,
    .i_spi_cs_n, .i_spi_mosi, .i_wp_n, .o_spi_miso, .o_spi_miso_oe_n,
    .o_array_rd, .o_idpage_rd, .o_lock_query, .o_addr, .o_rx_byte,
    .o_rx_byte_vld, .o_nv_start, .o_nv_kind, .o_busy, .o_status);
  // Released output reads as the inverse of its last bit
  wire miso_line = o_spi_miso_oe_n ? ~o_spi_miso : o_spi_miso;
  sec_spi_master u_m (.i_miso(miso_line), .o_sclk(i_spi_sclk),
    .o_cs_n(i_spi_cs_n), .o_mosi(i_spi_mosi), .o_rx(m_rx));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic take(input logic [11:0] s);
    if (q.size() == 0)
      chk(s, 12'hFFF);
    else
      chk(s, q.pop_front());
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Result watchers
  always @(negedge i_clk_sys)
  begin
    if (o_array_rd) take({3'h1, o_addr});
    if (o_idpage_rd) take({3'h2, o_addr});
    if (o_lock_query) take({3'h3, o_addr});
    if (o_rx_byte_vld) take({4'hC, o_rx_byte});
    if (o_nv_start) take({10'h280, o_nv_kind});
  end
  always @(u_m.got) take({4'h8, m_rx});
  task automatic ex(input logic [11:0] v);
    q.push_back(v);
  endtask
  task automatic sr(input logic [7:0] e);
    ex({4'h8, e});
    u_m.frame(8, 32'h05, 1);
  endtask
  task automatic wt;
    for (n = 0; n < TW + 100 && o_busy !== 1'b0; n++)
      @(negedge i_clk_sys);
    chk({11'h0, o_busy}, 12'h000);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400us;
    err_total++;
    wrap_up();
  end
  initial
  begin
    i_rst_n = 1'b0;
    i_wp_n = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    ex({4'h8, 8'hF0});
    ex({4'h8, 8'hF0});
    u_m.frame(8, 32'h05, 2);
    $display("test 1 done");
    u_m.frame(16, 32'h0603, 0);
    sr(8'hF2);
    u_m.frame(8, 32'h0C, 0);
    sr(8'hF0);
    ex({4'hC, 8'h0C});
    u_m.frame(16, 32'h010C, 0);
    sr(8'hF0);
    $display("test 2 done");
    u_m.frame(8, 32'h0E, 0);
    ex({4'hC, 8'h08});
    ex({10'h280, 2'h0});
    u_m.frame(16, 32'h0908, 0);
    sr(8'hF3);
    wt();
    sr(8'hF8);
    $display("test 3 done");
    repeat (3)
    begin
      lf = lfsr_next(lf);
      ex({3'h1, lf[8:0]});
      u_m.frame(16, {20'h0, lf[8], 3'h3, lf[7:0]}, 0);
    end
    ex({3'h2, 9'h005});
    u_m.frame(16, 32'h8305, 0);
    ex({3'h3, 9'h080});
    u_m.frame(16, 32'h8380, 0);
    $display("test 4 done");
    u_m.frame(8, 32'h06, 0);
    ex({4'hC, lf[15:8]});
    ex({10'h280, 2'h1});
    u_m.frame(24, {8'h02, 8'h10, lf[15:8]}, 0);
    u_m.frame(16, 32'h0310, 0);
    sr(8'hFB);
    wt();
    sr(8'hF8);
    u_m.frame(8, 32'h06, 0);
    ex({4'hC, lf[7:0]});
    u_m.frame(24, {8'h0A, 8'h20, lf[7:0]}, 0);
    sr(8'hFA);
    $display("test 5 done");
    ex({4'hC, 8'h00});
    u_m.frame(17, 32'h00200, 0);
    sr(8'hFA);
    @(negedge i_clk_sys);
    i_wp_n = 1'b0;
    ex({4'hC, 8'h00});
    u_m.frame(16, 32'h0100, 0);
    sr(8'hF8);
    @(negedge i_clk_sys);
    i_wp_n = 1'b1;
    u_m.frame(24, 32'hFF0300, 0);
    ex({4'h8, 8'hF8});
    u_m.frame(8, 32'h0D, 1);
    chk(12'(q.size()), 12'h000);
    $display("test 6 done");
    u_m.set_mode(1'b1);
    u_m.frame(8, 32'h06, 0);
    sr(8'hFA);
    $display("test 7 done");
    wrap_up();
  end
endmodule // sec_cmd_tb_top
bind sec_cmd sec_cmd_monitor #(.TW_CYC(TW_CYC)) u_mon (.i_clk_sys, .i_rst_n,
  .i_spi_sclk, .i_spi_cs_n, .i_spi_mosi, .i_wp_n, .o_spi_miso,
  .o_spi_miso_oe_n, .o_array_rd, .o_idpage_rd, .o_lock_query, .o_addr,
  .o_rx_byte, .o_rx_byte_vld, .o_nv_start, .o_nv_kind, .o_busy, .o_status);
`default_nettype wire
